// >>> ldo_top.sv
// Purpose: Per-port override of the address lookup destination, APB slave.
// Assumes: Lookup results arrive as one-cycle strobes synchronous to clk.
// Notes:   Result leaves one cycle after its strobe; ce low freezes all.
`include "ldo_defines.svh"

module ldo_top
    import ldo_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [`LDO_AW-1:0]  paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire logic                lk_valid,
    input  wire logic [1:0]          lk_port,
    input  wire ldo_result_t         lk_res,
    output logic                     fw_valid,
    output logic [1:0]               fw_port,
    output ldo_result_t              fw_res
);

    logic [31:0] ovr;          // Override register
    logic [31:0] next_ovr;     // Its next value
    logic        next_pready;  // Access phase answer
    logic [31:0] next_prdata;  // Read data for the access phase
    logic        next_pslverr; // Unmapped address flag
    logic        hit;          // Address decode
    logic        wr_go;        // Write completes this edge

    // Decode one field code into a destination mask; code 3 selects none
    function automatic logic [2:0] ldo_decode(input logic [1:0] code);
        logic [2:0] m;
        m = `LDO_MNONE;
        unique case (code)
            `LDO_P0: m = `LDO_M0;
            `LDO_P1: m = `LDO_M1;
            `LDO_P2: m = `LDO_M2;
            default: m = `LDO_MNONE;
        endcase
        return m;
    endfunction

    // APB decode and register next values
    always_comb
    begin
        hit          = (paddr == `LDO_ADDR);
        wr_go        = psel && penable && pready && pwrite && hit;
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !hit;
        next_prdata  = (psel && !penable && !pwrite && hit) ?
                       (ovr & `LDO_WMASK) : `LDO_ZERO;
        next_ovr     = ovr;
        if (wr_go)
        begin
            // Byte lanes picked by the strobes
            for (int b = 0; b < 4; b++)
            begin
                if (pstrb[b])
                begin
                    next_ovr[b*8 +: 8] = pwdata[b*8 +: 8];
                end
            end
            // Reserved bits are cleared so they always read zero
            next_ovr = next_ovr & `LDO_WMASK;
        end
    end

    // APB registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ovr     <= `LDO_RESET;
            pready  <= 1'b0;
            prdata  <= `LDO_ZERO;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            ovr     <= next_ovr;
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    logic        sel_en;        // Override enable of the ingress port
    logic [1:0]  sel_code;      // Override code of the ingress port
    logic        next_fw_valid; // Result strobe to forwarding
    logic [1:0]  next_fw_port;  // Ingress port to forwarding
    ldo_result_t next_fw_res;   // Result to forwarding

    // Override selection, using the register as it stands now
    always_comb
    begin
        sel_en   = 1'b0;
        sel_code = `LDO_P0;
        unique case (lk_port)
            `LDO_P0:
            begin
                sel_en   = ovr[`LDO_EN0];
                sel_code = ovr[`LDO_D0_LO +: 2];
            end
            `LDO_P1:
            begin
                sel_en   = ovr[`LDO_EN1];
                sel_code = ovr[`LDO_D1_LO +: 2];
            end
            `LDO_P2:
            begin
                sel_en   = ovr[`LDO_EN2];
                sel_code = ovr[`LDO_D2_LO +: 2];
            end
            default:
            begin
                sel_en   = 1'b0;
                sel_code = `LDO_P0;
            end
        endcase
        next_fw_valid     = lk_valid;
        next_fw_port      = lk_port;
        next_fw_res.assoc = lk_res.assoc;
        next_fw_res.dest  = sel_en ? ldo_decode(sel_code)
                                   : lk_res.dest;
    end

    // Result registers toward the forwarding stage
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fw_valid <= 1'b0;
            fw_port  <= `LDO_P0;
            fw_res   <= '0;
        end
        else if (ce)
        begin
            fw_valid <= next_fw_valid;
            fw_port  <= next_fw_port;
            fw_res   <= next_fw_res;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Port 2: enabled lookups take the programmed destination
    p2_override_a: assert property (
        ce && lk_valid && lk_port == `LDO_P2 && ovr[`LDO_EN2]
        |=> fw_res.dest == ldo_decode($past(ovr[`LDO_D2_LO +: 2])))
        else $error("port 2 override destination wrong");
    p2_code_a: assert property (
        ce && lk_valid && lk_port == `LDO_P2 && ovr[`LDO_EN2] &&
        ovr[`LDO_D2_LO +: 2] == `LDO_P1 |=> fw_res.dest == `LDO_M1)
        else $error("port 2 code 01 not port 1");
    p2_zero_a: assert property (
        ce && lk_valid && lk_port == `LDO_P2 && ovr[`LDO_EN2] &&
        ovr[`LDO_D2_LO +: 2] == `LDO_P0 |=> fw_res.dest == `LDO_M0)
        else $error("port 2 code 00 not port 0");

    // Port 1: enabled lookups take the programmed destination
    p1_override_a: assert property (
        ce && lk_valid && lk_port == `LDO_P1 && ovr[`LDO_EN1]
        |=> fw_res.dest == ldo_decode($past(ovr[`LDO_D1_LO +: 2])))
        else $error("port 1 override destination wrong");
    p1_code_a: assert property (
        ce && lk_valid && lk_port == `LDO_P1 && ovr[`LDO_EN1] &&
        ovr[`LDO_D1_LO +: 2] == `LDO_P2 |=> fw_res.dest == `LDO_M2)
        else $error("port 1 code 10 not port 2");
    p1_zero_a: assert property (
        ce && lk_valid && lk_port == `LDO_P1 && ovr[`LDO_EN1] &&
        ovr[`LDO_D1_LO +: 2] == `LDO_P0 |=> fw_res.dest == `LDO_M0)
        else $error("port 1 code 00 not port 0");

    // Port 0: enabled lookups take the programmed destination
    p0_override_a: assert property (
        ce && lk_valid && lk_port == `LDO_P0 && ovr[`LDO_EN0]
        |=> fw_res.dest == ldo_decode($past(ovr[`LDO_D0_LO +: 2])))
        else $error("port 0 override destination wrong");
    p0_code_a: assert property (
        ce && lk_valid && lk_port == `LDO_P0 && ovr[`LDO_EN0] &&
        ovr[`LDO_D0_LO +: 2] == `LDO_P1 |=> fw_res.dest == `LDO_M1)
        else $error("port 0 code 01 not port 1");
    p0_two_a: assert property (
        ce && lk_valid && lk_port == `LDO_P0 && ovr[`LDO_EN0] &&
        ovr[`LDO_D0_LO +: 2] == `LDO_P2 |=> fw_res.dest == `LDO_M2)
        else $error("port 0 code 10 not port 2");

    // Entry data and plain lookup destinations pass through
    assoc_pass_a: assert property (
        ce && lk_valid
        |=> fw_valid && fw_res.assoc == $past(lk_res.assoc))
        else $error("associated data altered");
    no_override_a: assert property (
        ce && lk_valid && !sel_en
        |=> fw_res.dest == $past(lk_res.dest))
        else $error("lookup destination lost without override");

    // Register writes land, every setup gets its answer
    write_apply_a: assert property (
        ce && wr_go && pstrb[0] && pwdata[`LDO_EN0] |=> ovr[`LDO_EN0])
        else $error("write not applied");
    apb_answer_a: assert property (
        ce && psel && !penable |=> pready && pslverr == !$past(hit))
        else $error("APB answer missing");

    ovr_used_c: cover property (ce && lk_valid && sel_en);
    apb_write_c: cover property (wr_go);
    apb_err_c: cover property (pready && pslverr);
    p2_ovr_c: cover property (ce && lk_valid && lk_port == `LDO_P2 && sel_en);

endmodule

// >>> ldo_defines.svh
// Purpose: Offsets, field positions and codes of the destination override.
// Assumes: APB byte addressing, one 32-bit word per register index.
// Notes:   Definitions only.
`ifndef LDO_DEFINES_SVH
`define LDO_DEFINES_SVH

// Register index and its APB byte address (index times four)
`define LDO_IDX        14'h180A
`define LDO_ADDR       {`LDO_IDX, 2'h0}
`define LDO_AW         16

// Field positions inside the override register
`define LDO_EN0        0
`define LDO_D0_LO      1
`define LDO_EN1        4
`define LDO_D1_LO      5
`define LDO_EN2        8
`define LDO_D2_LO      9

// Writable bits, reset value, zero word
`define LDO_WMASK      32'h0000_0777
`define LDO_RESET      32'h0000_0000
`define LDO_ZERO       32'h0000_0000

// Port codes and destination masks
`define LDO_P0         2'h0
`define LDO_P1         2'h1
`define LDO_P2         2'h2
`define LDO_M0         3'h1
`define LDO_M1         3'h2
`define LDO_M2         3'h4
`define LDO_MNONE      3'h0

`endif

// >>> ldo_pkg.sv
// Purpose: Types shared by the destination override block.
// Assumes: Three switch ports, destinations carried as a port mask.
// Notes:   Field widths follow the lookup table entry.
package ldo_pkg;

    // Associated data of a matched table entry, passed through untouched
    typedef struct packed {
        logic       age1_override;
        logic       static_entry;
        logic       age0_filter;
        logic       prio_en;
        logic [2:0] prio;
    } ldo_assoc_t;

    // One lookup result: destination port mask and associated data
    typedef struct packed {
        logic [2:0] dest;
        ldo_assoc_t assoc;
    } ldo_result_t;

endpackage

// >>> tb_ldo_top.sv
// Purpose: Self-checking bench for the lookup destination override.
// Assumes: Zero-wait APB slave; forward result one cycle after lk_valid.
// Notes:   Driver queues expected forwards, a monitor compares them.
`include "ldo_defines.svh"
module tb_ldo_top
    import ldo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk = 1'b0;     // 200 MHz clock
    logic               rst_n = 1'b0;   // Synchronous reset, active low
    logic               ce = 1'b1;      // Clock enable, held on except in the clock enable test
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [`LDO_AW-1:0] paddr = '0;
    logic [31:0]        pwdata = '0;
    logic [3:0]         pstrb = 4'hF;
    logic               pready, pslverr, fw_valid;
    logic [31:0]        prdata;
    logic               lk_valid = 1'b0;
    logic [1:0]         lk_port = 2'h0;
    logic [1:0]         fw_port;
    ldo_result_t        lk_res = '0;
    ldo_result_t        fw_res;
    logic [11:0]        exp_q[$];       // Expected forwards, oldest first
    logic [31:0]        mirror = '0;    // Bench copy of the register
    logic [31:0]        rv;             // Random word
    integer             seed = 32'hE51045EE;
    int                 bad_count = 0;
    int                 tests_run = 0;

    always #2.5 clk = ~clk;

    ldo_top ldo_top_i (.clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .lk_valid, .lk_port,
        .lk_res, .fw_valid, .fw_port, .fw_res);

    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic results();
        $display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One APB transfer; checks read data and error against the mirror
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            bad_count++;
            results();
        end
        else
        begin
            check(pslverr, a != `LDO_ADDR);
            if (!wr)
                check(prdata, (a == `LDO_ADDR) ? mirror : 0);
            else if (a == `LDO_ADDR)
            begin
                for (int b = 0; b < 4; b++)
                    if (s[b])
                        mirror[8*b +: 8] = d[8*b +: 8];
                mirror = mirror & `LDO_WMASK;
            end
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Send one lookup and queue its expected forward
    task automatic lk_send(input logic [1:0] p, input ldo_result_t r);
        logic [2:0] dst;
        dst = r.dest;
        if (p != 2'h3 && mirror[4*p] == 1'b1)
            dst = (mirror[4*p+1 +: 2] == 2'h3) ? 3'h0
                : 3'h1 << mirror[4*p+1 +: 2];
        @(posedge clk);
        lk_valid <= 1'b1;
        lk_port <= p;
        lk_res <= r;
        exp_q.push_back({p, dst, r.assoc});
    endtask

    // Monitor: each forward is matched with the oldest expectation
    always @(posedge clk)
    begin
        if (fw_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(32'h1, 32'h0);
            else
                check({fw_port, fw_res}, exp_q.pop_front());
        end
    end

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `LDO_ADDR, 32'h0, 4'hF);
        apb(1'b1, `LDO_ADDR, 32'hFFFFFFFF, 4'hF);
        apb(1'b0, `LDO_ADDR, 32'h0, 4'hF);
        $display("Test reset and access bits done");
        apb(1'b1, `LDO_ADDR + 16'h4, 32'h0, 4'hF);
        apb(1'b0, `LDO_ADDR + 16'h4, 32'h0, 4'hF);
        apb(1'b0, `LDO_ADDR, 32'h0, 4'hF);
        apb(1'b1, `LDO_ADDR, 32'h0, 4'hF);
        apb(1'b1, `LDO_ADDR, 32'hFFFFFFFF, 4'h2);
        apb(1'b0, `LDO_ADDR, 32'h0, 4'hF);
        $display("Test unmapped and strobes done");
        // Every code in every field, all enables on
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, `LDO_ADDR, (c << 9) | (c << 5) | (c << 1) | 32'h111,
                4'hF);
            for (int p = 0; p < 4; p++)
            begin
                rv = $random(seed);
                lk_send(p[1:0], rv[9:0]);
            end
            @(posedge clk);
            lk_valid <= 1'b0;
        end
        $display("Test all codes done");
        // Random settings, back-to-back lookups
        for (int i = 0; i < 12; i++)
        begin
            apb(1'b1, `LDO_ADDR, $random(seed), 4'hF);
            for (int k = 0; k < 8; k++)
            begin
                rv = $random(seed);
                lk_send(rv[1:0], rv[11:2]);
            end
            @(posedge clk);
            lk_valid <= 1'b0;
        end
        repeat (4) @(posedge clk);
        check(exp_q.size(), 0);
        $display("Test random overrides done");
        // Clock enable low: a held lookup strobe must not be taken
        apb(1'b1, `LDO_ADDR, 32'hFFFFFFFF, 4'hF);
        ce <= 1'b0;
        lk_valid <= 1'b1;
        repeat (3) @(posedge clk);
        check(fw_valid, 1'b0);
        ce <= 1'b1;
        lk_valid <= 1'b0;
        repeat (3) @(posedge clk);
        // Reset in mid-run clears the register
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        mirror = '0;
        apb(1'b0, `LDO_ADDR, 32'h0, 4'hF);
        $display("Test clock enable and reset done");
        results();
    end
endmodule
